//--- hdl/temp_parser.sv
// Escape sequence parser, mode store and key routing top
// Functional notes
// - ESC byte starts a sequence, never displayed
// - Sequence bytes only change modes, not shown
// - ESC then left bracket opens parameterised sequence
// - ESC plus one character selects a function
// - Semicolon separated parameters, one final character
// - Parameters are accumulated decimal ASCII digits
// - Question mark private set, greater-than vendor set
// - Final h sets, final l resets mode
// - Parameter 12 set stops keyboard echo
// - Echo reset shows keys, CR as CR LF
// - Private 2 selects standard or legacy dialect
// - Each dialect executes only its own sequences
// - Legacy ESC less-than returns to standard dialect
// - Standard off ignores all further standard sequences
// - Private 1 selects cursor key application mode
// - Cursor key mode reset after power-up
// - Standard normal cursor keys send ESC [ X
// - Standard application cursor keys send ESC O X
// - Legacy cursor keys send ESC X only
// - Keypad numeric mode sends keycap values
// - Keypad application mode sends ESC O sequences
// - ESC equals application, ESC greater-than numeric
// - Several parameters apply action to each mode
`timescale 1ns/100ps
module temp_parser #(
   parameter int PARAM_W = 8
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Host receive
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // Host transmit
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   input  wire logic        tx_ready,
   // Display path
   output logic             disp_valid,
   output logic      [7:0]  disp_data,
   // Keyboard text
   input  wire logic        kbd_valid,
   input  wire logic [7:0]  kbd_data,
   output logic             kbd_ready,
   // Cursor keys
   input  wire logic        cur_valid,
   input  wire logic [1:0]  cur_dir,
   output logic             cur_ready,
   // Numeric keypad
   input  wire logic        kp_valid,
   input  wire logic [7:0]  kp_char,
   input  wire logic [7:0]  kp_app_code,
   output logic             kp_ready,
   // Mode state
   output logic             local_echo_suppress_mode,
   output logic             dialect_select_mode,
   output logic             cursor_key_application_mode,
   output logic             keypad_application_mode
);
   import temp_pkg::*;

   typedef struct packed {
      temp_pstate_t pst;
      temp_prefix_t prefix;
      logic         first;
      logic         bad;
      logic [2:0]   hits;
      logic         echo_sup;
      logic         std_dia;
      logic         ckm;
      logic         kpam;
      logic         disp_valid;
      logic [7:0]   disp_data;
      logic         lf_pend;
      logic [31:0]  rdata;
      logic [15:0]  discards;
   } temp_state_t;

   localparam temp_state_t RESET_STATE = '{
      pst: P_TEXT, prefix: PFX_NONE, first: 1'b0, bad: 1'b0, hits: 3'h0,
      echo_sup: RST_ECHO_SUP, std_dia: RST_STD_DIA, ckm: RST_CKM, kpam: RST_KPAM,
      disp_valid: 1'b0, disp_data: 8'h00, lf_pend: 1'b0, rdata: 32'h0000_0000,
      discards: 16'h0000};

   // Classify one parameter: {bad, cursor hit, dialect hit, echo hit}
   function automatic logic [3:0] classify(input temp_prefix_t pfx,
                                           input logic [PARAM_W-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      if (v != '0) begin
         unique case (pfx)
            PFX_NONE:     r = (v == PARAM_W'(PARAM_ECHO)) ? 4'h1 : 4'h8;
            PFX_STD_PRIV: begin
               if (v == PARAM_W'(PARAM_DIALECT)) begin
                  r = 4'h2;
               end else if (v == PARAM_W'(PARAM_CURSOR)) begin
                  r = 4'h4;
               end else begin
                  r = 4'h8;
               end
            end
            default:      r = 4'h8;
         endcase
      end
      return r;
   endfunction

   temp_state_t        s_q;
   temp_state_t        s_d;
   temp_key_if         key ();
   logic [PARAM_W-1:0] pval;
   logic [3:0]         pcls;
   logic               csi_byte;
   logic               acc_clear;
   logic               acc_digit;
   logic               kbd_take;
   logic               seq_ok;

   assign pcls      = classify(s_q.prefix, pval);
   assign csi_byte  = rx_valid && (s_q.pst == P_CSI);
   assign acc_clear = (rx_valid && s_q.pst == P_ESC && rx_data == CH_LBRACK) ||
                      (csi_byte && rx_data == CH_SEMI);
   assign acc_digit = csi_byte && is_digit(rx_data);
   assign seq_ok    = !s_q.bad && !pcls[3] && (rx_data == CH_SET || rx_data == CH_RESET);

   temp_param_acc #(.W(PARAM_W)) u_acc (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .clear       (acc_clear),
      .digit_valid (acc_digit),
      .digit       (rx_data[3:0]),
      .value       (pval)
   );

   temp_key_enc u_enc (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .key      (key.enc),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_ready (tx_ready)
   );

   // Key arbitration: text, then cursor, then keypad
   assign kbd_ready = key.req_ready && !s_q.lf_pend && !rx_valid;
   assign cur_ready = key.req_ready && !kbd_valid;
   assign kp_ready  = key.req_ready && !kbd_valid && !cur_valid;
   assign kbd_take  = kbd_valid && kbd_ready;

   assign key.req_valid   = kbd_take || (cur_valid && cur_ready) || (kp_valid && kp_ready);
   assign key.req_kind    = kbd_valid ? K_TEXT : (cur_valid ? K_CURSOR : K_KEYPAD);
   assign key.req_code    = kbd_valid ? kbd_data : (cur_valid ? {6'h00, cur_dir} : kp_char);
   assign key.req_app     = kp_app_code;
   assign key.std_dialect = s_q.std_dia;
   assign key.cursor_app  = s_q.ckm;
   assign key.keypad_app  = s_q.kpam;

   always_comb begin
      s_d            = s_q;
      s_d.disp_valid = 1'b0;
      s_d.rdata      = 32'h0000_0000;
      // Software access
      if (reg_wr && reg_addr == REG_MODE) begin
         s_d.echo_sup = reg_wdata[MODE_ECHO_BIT];
         s_d.std_dia  = reg_wdata[MODE_DIALECT_BIT];
         s_d.ckm      = reg_wdata[MODE_CURSOR_BIT];
         s_d.kpam     = reg_wdata[MODE_KEYPAD_BIT];
      end
      if (reg_wr && reg_addr == REG_DISCARD) begin
         s_d.discards = 16'h0000;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_MODE:    s_d.rdata = {28'h0, s_q.kpam, s_q.ckm, s_q.std_dia, s_q.echo_sup};
            REG_STATUS:  s_d.rdata = {26'h0, s_q.lf_pend, s_q.bad, s_q.prefix, s_q.pst};
            REG_DISCARD: s_d.rdata = {16'h0, s_q.discards};
            default:     s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Host byte stream
      if (rx_valid) begin
         unique case (s_q.pst)
            P_TEXT: begin
               if (rx_data == CH_ESC) begin
                  s_d.pst = P_ESC;
               end else begin
                  s_d.disp_valid = 1'b1;
                  s_d.disp_data  = rx_data;
               end
            end
            P_ESC: begin
               s_d.pst = P_TEXT;
               if (rx_data == CH_ESC) begin
                  s_d.pst = P_ESC;
               end else if (s_q.std_dia && rx_data == CH_LBRACK) begin
                  s_d.pst    = P_CSI;
                  s_d.prefix = PFX_NONE;
                  s_d.first  = 1'b1;
                  s_d.bad    = 1'b0;
                  s_d.hits   = 3'h0;
               end else if (rx_data == CH_EQ) begin
                  s_d.kpam = 1'b1;
               end else if (rx_data == CH_GT) begin
                  s_d.kpam = 1'b0;
               end else if (!s_q.std_dia && rx_data == CH_LT) begin
                  s_d.std_dia = 1'b1;
               end else begin
                  s_d.discards = s_d.discards + 16'h0001;
               end
            end
            P_CSI: begin
               s_d.first = 1'b0;
               if (rx_data == CH_ESC) begin
                  s_d.pst      = P_ESC;
                  s_d.discards = s_d.discards + 16'h0001;
               end else if (s_q.first && rx_data == CH_QMARK) begin
                  s_d.prefix = PFX_STD_PRIV;
               end else if (s_q.first && rx_data == CH_GT) begin
                  s_d.prefix = PFX_VENDOR;
               end else if (is_digit(rx_data)) begin
                  s_d.bad = s_q.bad;
               end else if (rx_data == CH_SEMI) begin
                  s_d.hits = s_q.hits | pcls[2:0];
                  s_d.bad  = s_q.bad | pcls[3];
               end else if (is_final(rx_data)) begin
                  s_d.pst = P_TEXT;
                  if (seq_ok) begin
                     if (s_q.hits[0] || pcls[0]) begin
                        s_d.echo_sup = (rx_data == CH_SET);
                     end
                     if (s_q.hits[1] || pcls[1]) begin
                        s_d.std_dia = (rx_data == CH_SET);
                     end
                     if (s_q.hits[2] || pcls[2]) begin
                        s_d.ckm = (rx_data == CH_SET);
                     end
                  end else begin
                     s_d.discards = s_d.discards + 16'h0001;
                  end
               end else begin
                  s_d.bad = 1'b1;
               end
            end
            default: begin
               s_d.pst = P_TEXT;
            end
         endcase
      end
      // Local echo of keyboard text
      if (kbd_take && !s_q.echo_sup) begin
         s_d.disp_valid = 1'b1;
         s_d.disp_data  = kbd_data;
         s_d.lf_pend    = (kbd_data == CH_CR);
      end else if (s_q.lf_pend && !s_d.disp_valid) begin
         s_d.disp_valid = 1'b1;
         s_d.disp_data  = CH_LF;
         s_d.lf_pend    = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata                   = s_q.rdata;
   assign disp_valid                  = s_q.disp_valid;
   assign disp_data                   = s_q.disp_data;
   assign local_echo_suppress_mode    = s_q.echo_sup;
   assign dialect_select_mode         = s_q.std_dia;
   assign cursor_key_application_mode = s_q.ckm;
   assign keypad_application_mode     = s_q.kpam;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   esc_hidden_a: assert property (
      rx_valid && rx_data == CH_ESC && !s_q.lf_pend |=> !disp_valid)
      else $error("Escape byte reached the display");
   csi_hidden_a: assert property (
      csi_byte && !s_q.lf_pend |=> !disp_valid)
      else $error("Sequence byte reached the display");
   csi_entry_a: assert property (
      rx_valid && s_q.pst == P_ESC && rx_data == CH_LBRACK && s_q.std_dia |=> s_q.pst == P_CSI)
      else $error("Introducer not recognised");
   esc_single_a: assert property (
      rx_valid && s_q.pst == P_ESC && rx_data != CH_ESC &&
      !(s_q.std_dia && rx_data == CH_LBRACK) |=> s_q.pst == P_TEXT)
      else $error("Two byte sequence not closed");
   echo_set_a: assert property (
      csi_byte && rx_data == CH_SET && s_q.prefix == PFX_NONE && s_q.hits == 3'h0 &&
      !s_q.bad && pval == PARAM_W'(PARAM_ECHO) && !reg_wr |=> local_echo_suppress_mode)
      else $error("Echo suppress not set");
   cursor_reset_a: assert property (
      csi_byte && rx_data == CH_RESET && s_q.prefix == PFX_STD_PRIV && !s_q.bad &&
      pval == PARAM_W'(PARAM_CURSOR) && !reg_wr |=> !cursor_key_application_mode)
      else $error("Cursor key mode not reset");
   echo_crlf_a: assert property (
      kbd_take && !s_q.echo_sup && kbd_data == CH_CR |=>
         disp_valid && disp_data == CH_CR && s_q.lf_pend ##1
         disp_valid && (disp_data == CH_LF || s_q.lf_pend))
      else $error("Carriage return echo wrong");
   echo_quiet_a: assert property (
      kbd_take && s_q.echo_sup && !s_q.lf_pend |=> !disp_valid)
      else $error("Keyboard echoed while suppressed");
   legacy_exit_a: assert property (
      rx_valid && s_q.pst == P_ESC && !s_q.std_dia && rx_data == CH_LT && !reg_wr
      |=> dialect_select_mode)
      else $error("Legacy exit ignored");
   legacy_no_csi_a: assert property (
      rx_valid && s_q.pst == P_ESC && !s_q.std_dia && rx_data == CH_LBRACK |=> s_q.pst == P_TEXT)
      else $error("Control sequence taken in legacy dialect");
   keypad_app_a: assert property (
      rx_valid && s_q.pst == P_ESC && rx_data == CH_EQ && !reg_wr |=> keypad_application_mode)
      else $error("Keypad application mode not entered");
   unknown_keep_a: assert property (
      csi_byte && is_final(rx_data) && rx_data != CH_SET && rx_data != CH_RESET && !reg_wr
      |=> $stable({s_q.echo_sup, s_q.std_dia, s_q.ckm, s_q.kpam}))
      else $error("Unknown sequence changed a mode");
   multi_hit_a: assert property (
      csi_byte && rx_data == CH_SEMI |=> (s_q.hits & $past(pcls[2:0])) == $past(pcls[2:0]))
      else $error("Parameter hit lost at separator");

   echo_set_c: cover property (csi_byte && rx_data == CH_SET && seq_ok && pcls[0]);
   multi_param_c: cover property (csi_byte && rx_data == CH_SET && seq_ok && s_q.hits != 3'h0);
   legacy_exit_c: cover property (rx_valid && s_q.pst == P_ESC && !s_q.std_dia &&
                                  rx_data == CH_LT);
   crlf_echo_c: cover property (s_q.lf_pend && disp_valid && disp_data == CH_CR);

endmodule

//--- hdl/temp_pkg.sv
// Shared constants, types and decode helpers for the escape and mode parser
package temp_pkg;

   // Character codes
   localparam logic [7:0] CH_ESC    = 8'h1b;
   localparam logic [7:0] CH_LBRACK = 8'h5b;
   localparam logic [7:0] CH_SEMI   = 8'h3b;
   localparam logic [7:0] CH_QMARK  = 8'h3f;
   localparam logic [7:0] CH_GT     = 8'h3e;
   localparam logic [7:0] CH_LT     = 8'h3c;
   localparam logic [7:0] CH_EQ     = 8'h3d;
   localparam logic [7:0] CH_SET    = 8'h68;
   localparam logic [7:0] CH_RESET  = 8'h6c;
   localparam logic [7:0] CH_APP    = 8'h4f;
   localparam logic [7:0] CH_DIR0   = 8'h41;
   localparam logic [7:0] CH_CR     = 8'h0d;
   localparam logic [7:0] CH_LF     = 8'h0a;
   localparam logic [7:0] CH_DIGIT0 = 8'h30;
   localparam logic [7:0] CH_DIGIT9 = 8'h39;
   localparam logic [7:0] CH_FIN_LO = 8'h40;
   localparam logic [7:0] CH_FIN_HI = 8'h7e;

   // Parameter values naming modes
   localparam logic [7:0] PARAM_ECHO    = 8'h0c;
   localparam logic [7:0] PARAM_CURSOR  = 8'h01;
   localparam logic [7:0] PARAM_DIALECT = 8'h02;

   // Register offsets and mode field layout
   localparam logic [3:0] REG_MODE    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_DISCARD = 4'h8;
   localparam int         MODE_ECHO_BIT    = 0;
   localparam int         MODE_DIALECT_BIT = 1;
   localparam int         MODE_CURSOR_BIT  = 2;
   localparam int         MODE_KEYPAD_BIT  = 3;
   localparam logic       RST_ECHO_SUP = 1'b0;
   localparam logic       RST_STD_DIA  = 1'b1;
   localparam logic       RST_CKM      = 1'b0;
   localparam logic       RST_KPAM     = 1'b0;

   typedef enum logic [1:0] {P_TEXT, P_ESC, P_CSI} temp_pstate_t;
   typedef enum logic [1:0] {PFX_NONE, PFX_STD_PRIV, PFX_VENDOR} temp_prefix_t;
   typedef enum logic [1:0] {K_TEXT, K_CURSOR, K_KEYPAD} temp_kind_t;

   function automatic logic is_digit(input logic [7:0] c);
      return (c >= CH_DIGIT0) && (c <= CH_DIGIT9);
   endfunction

   function automatic logic is_final(input logic [7:0] c);
      return (c >= CH_FIN_LO) && (c <= CH_FIN_HI);
   endfunction

endpackage

//--- hdl/temp_key_if.sv
// Key transmit request channel between parser top and key encoder
`timescale 1ns/100ps
interface temp_key_if;
   import temp_pkg::*;
   logic             req_valid;
   logic             req_ready;
   temp_kind_t       req_kind;
   logic [7:0]       req_code;
   logic [7:0]       req_app;
   logic             std_dialect;
   logic             cursor_app;
   logic             keypad_app;

   modport top (output req_valid, req_kind, req_code, req_app, std_dialect, cursor_app,
                keypad_app, input req_ready);
   modport enc (input req_valid, req_kind, req_code, req_app, std_dialect, cursor_app,
                keypad_app, output req_ready);
endinterface

//--- hdl/temp_param_acc.sv
// Decimal parameter accumulator, saturating
`timescale 1ns/100ps
module temp_param_acc #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Control
   input  wire logic         clear,
   input  wire logic         digit_valid,
   input  wire logic [3:0]   digit,
   // Result
   output logic      [W-1:0] value
);
   import temp_pkg::*;

   typedef struct packed {
      logic [W-1:0] val;
   } temp_acc_t;

   temp_acc_t       s_q;
   temp_acc_t       s_d;
   logic [W+4:0]    prod;

   always_comb begin
      s_d  = s_q;
      prod = (W+5)'(s_q.val) * (W+5)'(10) + (W+5)'(digit);
      if (clear) begin
         s_d.val = '0;
      end else if (digit_valid) begin
         s_d.val = (prod > (W+5)'({W{1'b1}})) ? {W{1'b1}} : prod[W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign value = s_q.val;

   accum_step_a: assert property (@(posedge sys_clk) disable iff (rst)
      digit_valid && !clear && s_q.val < W'(25) |=>
         s_q.val == W'($past(s_q.val) * 10 + $past(digit)))
      else $error("Decimal accumulate step wrong");

endmodule

//--- hdl/temp_key_enc.sv
// Cursor, keypad and text key encoder toward the host
`timescale 1ns/100ps
module temp_key_enc (
   // Clock and reset
   input  wire logic  sys_clk,
   input  wire logic  rst,
   // Requests
   temp_key_if.enc    key,
   // Host transmit
   output logic       tx_valid,
   output logic [7:0] tx_data,
   input  wire logic  tx_ready
);
   import temp_pkg::*;

   typedef struct packed {
      logic [1:0]      cnt;
      logic [2:0][7:0] sh;
   } temp_enc_t;

   temp_enc_t s_q;
   temp_enc_t s_d;
   logic      take;

   assign take          = key.req_valid && key.req_ready;
   assign key.req_ready = (s_q.cnt == 2'd0);
   assign tx_valid      = (s_q.cnt != 2'd0);
   assign tx_data       = s_q.sh[0];

   always_comb begin
      s_d = s_q;
      if (tx_valid && tx_ready) begin
         s_d.sh  = {8'h00, s_q.sh[2:1]};
         s_d.cnt = s_q.cnt - 2'd1;
      end
      if (take) begin
         unique case (key.req_kind)
            K_TEXT: begin
               s_d.sh  = {16'h0000, key.req_code};
               s_d.cnt = 2'd1;
            end
            K_CURSOR: begin
               if (!key.std_dialect) begin
                  s_d.sh  = {8'h00, CH_DIR0 + key.req_code, CH_ESC};
                  s_d.cnt = 2'd2;
               end else if (key.cursor_app) begin
                  s_d.sh  = {CH_DIR0 + key.req_code, CH_APP, CH_ESC};
                  s_d.cnt = 2'd3;
               end else begin
                  s_d.sh  = {CH_DIR0 + key.req_code, CH_LBRACK, CH_ESC};
                  s_d.cnt = 2'd3;
               end
            end
            K_KEYPAD: begin
               if (key.keypad_app) begin
                  s_d.sh  = {key.req_app, CH_APP, CH_ESC};
                  s_d.cnt = 2'd3;
               end else begin
                  s_d.sh  = {16'h0000, key.req_code};
                  s_d.cnt = 2'd1;
               end
            end
            default: begin
               s_d.cnt = 2'd0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   cur_std_a: assert property (
      take && key.req_kind == K_CURSOR && key.std_dialect && !key.cursor_app |=>
         tx_valid && tx_data == CH_ESC && s_q.sh[1] == CH_LBRACK && s_q.cnt == 2'd3)
      else $error("Normal cursor key sequence wrong");
   cur_app_a: assert property (
      take && key.req_kind == K_CURSOR && key.std_dialect && key.cursor_app |=>
         tx_data == CH_ESC && s_q.sh[1] == CH_APP && s_q.sh[2] == CH_DIR0 + $past(key.req_code))
      else $error("Application cursor key sequence wrong");
   cur_legacy_a: assert property (
      take && key.req_kind == K_CURSOR && !key.std_dialect |=>
         s_q.cnt == 2'd2 && s_q.sh[1] == CH_DIR0 + $past(key.req_code))
      else $error("Legacy cursor key sequence wrong");
   kp_numeric_a: assert property (
      take && key.req_kind == K_KEYPAD && !key.keypad_app |=>
         s_q.cnt == 2'd1 && tx_data == $past(key.req_code))
      else $error("Numeric keypad value wrong");
   kp_app_a: assert property (
      take && key.req_kind == K_KEYPAD && key.keypad_app |=>
         tx_data == CH_ESC && s_q.sh[1] == CH_APP)
      else $error("Application keypad prefix wrong");

endmodule

//--- tb/temp_host_model.sv
// Host model: sends bytes to the device, takes its transmit bytes
`timescale 1ns/100ps
module temp_host_model (
   // Clock and host lines
   input  wire logic       sys_clk,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready
);
   logic [7:0] got[$];
   bit         slow = 0;
   initial {rx_valid, rx_data, tx_ready} = '0;
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= !slow || 1'($urandom_range(1));
   end
   task automatic send(input logic [7:0] b);
      @(posedge sys_clk);
      {rx_valid, rx_data} <= {1'b1, b};
      @(posedge sys_clk);
      {rx_valid, rx_data} <= {1'b0, ~b};
   endtask
endmodule

//--- tb/temp_parser_tb_top.sv
// Self-checking bench for the escape and mode parser
`timescale 1ns/100ps
module temp_parser_tb_top;
   logic        sys_clk = 0, rst = 1, reg_rd = 0, kbd_valid = 0, cur_valid = 0, kp_valid = 0;
   logic        reg_wr = 0, rx_valid, tx_valid, tx_ready, disp_valid;
   logic        kbd_ready, cur_ready, kp_ready;
   logic [3:0]  reg_addr = 0, m;
   logic [7:0]  rx_data, tx_data, disp_data, kd = 0, t, dq[$];
   logic [31:0] reg_wdata = 0, reg_rdata;
   int          err_total = 0, checked = 0;
   string       md[3] = '{"[", "O", ""};
   temp_parser i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .disp_valid(disp_valid), .disp_data(disp_data), .kbd_valid(kbd_valid), .kbd_data(kd),
      .kbd_ready(kbd_ready), .cur_valid(cur_valid), .cur_dir(kd[1:0]), .cur_ready(cur_ready),
      .kp_valid(kp_valid), .kp_char(kd), .kp_app_code(kd), .kp_ready(kp_ready),
      .local_echo_suppress_mode(m[0]), .dialect_select_mode(m[1]),
      .cursor_key_application_mode(m[2]), .keypad_application_mode(m[3]));
   temp_host_model i_host (.sys_clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (disp_valid)
         dq.push_back(disp_data);
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      give_verdict();
   end
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic step(input string w, input string s, input logic [3:0] e);
      i_host.send(temp_pkg::CH_ESC);
      foreach (s[i])
         i_host.send(s[i]);
      repeat (2) @(posedge sys_clk);
      chk(w, e, m);
      $display("test %s done", w);
   endtask
   task automatic kt(input int k, input logic [7:0] v, input string e);
      @(posedge sys_clk);
      kd <= v;
      {kbd_valid, cur_valid, kp_valid} <= 3'(3'b100 >> k);
      do @(negedge sys_clk); while (!(k == 0 ? kbd_ready : k == 1 ? cur_ready : kp_ready));
      @(posedge sys_clk);
      {kbd_valid, cur_valid, kp_valid} <= 3'b000;
      wait (i_host.got.size() >= e.len());
      foreach (e[i])
         chk("tx", e[i], i_host.got.pop_front());
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 0;
      @(negedge sys_clk);
      chk("reg", e, reg_rdata);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask
   task automatic give_verdict();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      void'($urandom(3870));
      repeat (12) @(posedge sys_clk);
      rst <= 0;
      step("echo set", "[12h", 4'b0011);
      t = 8'h61 + 8'($urandom_range(25));
      kt(0, t, $sformatf("%c", t));
      repeat (2) @(posedge sys_clk);
      chk("quiet", 32'h0, dq.size());
      step("echo reset", "[12l", 4'b0010);
      kt(0, 8'h0d, "\r");
      repeat (4) @(posedge sys_clk);
      chk("echo", 16'h0d0a, {dq[0], dq[1]});
      for (int n = 0; n < 3; n++) begin
         i_host.slow = n == 1;
         for (int d = 0; d < 4; d++)
            kt(1, 8'(d), $sformatf("\033%s%c", md[n], 65 + d));
         step("cursor", n == 0 ? "[?1h" : n == 1 ? "[?2l" : "[12h",
            n == 0 ? 4'b0110 : 4'b0100);
      end
      chk("text", 24'h313268, {dq[2], dq[3], dq[4]});
      step("legacy exit", "<", 4'b0110);
      step("keypad app", "=", 4'b1110);
      kt(2, 8'h70, "\033Op");
      step("keypad num", ">", 4'b0110);
      kt(2, 8'h35, "5");
      rd(temp_pkg::REG_MODE, 32'h6);
      rd(4'hc, 32'h0);
      step("multi", "[?1;2l", 4'b0000);
      wr(temp_pkg::REG_DISCARD, 32'h0);
      step("legacy exit", "<", 4'b0010);
      step("unknown", "[?7;1h", 4'b0010);
      step("bad final", "[12m", 4'b0010);
      rd(temp_pkg::REG_DISCARD, 32'h2);
      step("cursor set", "[?1h", 4'b0110);
      step("cursor reset", "[?1l", 4'b0010);
      wr(temp_pkg::REG_MODE, 32'h9);
      rd(temp_pkg::REG_MODE, 32'h9);
      give_verdict();
   end
endmodule
